// File: shared/debug_ctl_pkg.sv
package debug_ctl_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int SCAN_W = 38;
    localparam int CTRL_W = 6;
    localparam int STAT_W = 13;
    localparam int CV_W = 9;
    localparam int CM_W = 8;
    localparam int CBUS_W = 10;
    localparam int CORE_CTRL_W = 5;
    localparam int NUM_UNITS = 2;
    localparam int EXT_W = 2;

    // scan word layout: data, address, read/write
    localparam int SCAN_ADDR_LSB = 32;
    localparam int SCAN_RW_BIT = 37;

    // register addresses on the scan path
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_UNIT0 = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_UNIT1 = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_UNIT_MASK = 5'h18;
    localparam logic [2:0] WP_AV = 3'h0;
    localparam logic [2:0] WP_AM = 3'h1;
    localparam logic [2:0] WP_DV = 3'h2;
    localparam logic [2:0] WP_DM = 3'h3;
    localparam logic [2:0] WP_CV = 3'h4;
    localparam logic [2:0] WP_CM = 3'h5;

    // debug control fields
    localparam int CTRL_DISABLE_BIT = 5;
    localparam int CTRL_MONITOR_BIT = 4;
    localparam int CTRL_SBZ_BIT = 3;
    localparam int CTRL_INHIBIT_BIT = 2;
    localparam int CTRL_FORCE_REQ_BIT = 1;
    localparam int CTRL_FORCE_ACK_BIT = 0;
    localparam logic [CTRL_W-1:0] CTRL_WR_MASK = 6'h37;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // debug status fields
    localparam int STAT_REQ_ENTRY_BIT = 12;
    localparam int STAT_COMPRESSED_BIT = 4;
    localparam int STAT_HTRANS_BIT = 3;
    localparam int STAT_IRQ_EN_BIT = 2;
    localparam int STAT_REQ_BIT = 1;
    localparam int STAT_ACK_BIT = 0;
    localparam logic STAT_ENTRY_RESET = 1'b0;

    // combined control bus positions
    localparam int CB_ADDR_HI = 4;
    localparam int CB_DATA_LO = 5;
    localparam int CB_DATA_HI = 7;
    localparam int CB_EXT = 5;
    localparam int CB_RANGE = 6;
    localparam int CB_CHAIN = 7;
    localparam int CB_VALID = 8;
    localparam int CB_IN_DEBUG = 9;
    localparam int CV_ENABLE_BIT = 8;

    localparam logic [DATA_W-1:0] WP_RESET = 32'h0000_0000;
endpackage : debug_ctl_pkg

// File: design/watch_comparator.sv
`timescale 1ns/1ps
`default_nettype none
module watch_comparator import debug_ctl_pkg::*; (
    input wire logic [DATA_W-1:0] addr_value,
    input wire logic [DATA_W-1:0] addr_mask,
    input wire logic [DATA_W-1:0] data_value,
    input wire logic [DATA_W-1:0] data_mask,
    input wire logic [CV_W-1:0] ctrl_value,
    input wire logic [CM_W-1:0] ctrl_mask,
    input wire logic [DATA_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data,
    input wire logic [CBUS_W-1:0] ctrl_bus,
    output logic addr_match,
    output logic data_match,
    output logic unit_match
);
    logic [DATA_W+CB_ADDR_HI:0] addr_cmp;
    logic [DATA_W+CB_DATA_HI-CB_DATA_LO:0] data_cmp;

    // masked xnor over {address, C[4:0]} and {data, C[7:5]}
    always_comb begin
        addr_cmp = ~({addr_value, ctrl_value[CB_ADDR_HI:0]} ^ {bus_addr, ctrl_bus[CB_ADDR_HI:0]})
                   | {addr_mask, ctrl_mask[CB_ADDR_HI:0]};
        data_cmp = ~({data_value, ctrl_value[CB_DATA_HI:CB_DATA_LO]} ^ {bus_data, ctrl_bus[CB_DATA_HI:CB_DATA_LO]})
                   | {data_mask, ctrl_mask[CB_DATA_HI:CB_DATA_LO]};
        addr_match = &addr_cmp;
        data_match = &data_cmp;
        // no triggers on accesses made while the core is halted
        unit_match = addr_match & data_match & ctrl_value[CV_ENABLE_BIT]
                     & ctrl_bus[CB_VALID] & ~ctrl_bus[CB_IN_DEBUG];
    end
endmodule : watch_comparator
`default_nettype wire

// File: design/debug_control_status.sv
`timescale 1ns/1ps
`default_nettype none
module debug_control_status import debug_ctl_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic tck,
    input wire logic tap_reset,
    input wire logic tdi,
    input wire logic scan_capture,
    input wire logic scan_shift,
    input wire logic scan_update,
    input wire logic tap_idle,
    output logic tdo,
    input wire logic halt_request,
    input wire logic [EXT_W-1:0] external_debug_input,
    input wire logic core_internal_halt_ack,
    input wire logic compressed_state_flag,
    input wire logic htrans1,
    input wire logic [CORE_CTRL_W-1:0] core_ctrl,
    input wire logic access_valid,
    input wire logic [DATA_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data,
    input wire logic external_abort,
    input wire logic debug_abort_clear,
    output logic combined_halt_request_out,
    output logic halt_acknowledge,
    output logic core_interrupt_enable,
    output logic breakpoint_halt,
    output logic breakpoint_abort,
    output logic debug_abort_flag,
    output logic chain_latch_output,
    output logic range_match_output
);
    // tck domain: scan chain
    logic [SCAN_W-1:0] shift_reg, shift_next, hold_reg, hold_next;
    logic req_tgl_reg, req_tgl_next, tdo_reg, tdo_next;
    logic ack_s1_reg, ack_s2_reg;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic ack_tgl_reg, ack_tgl_next;

    always_ff @(posedge tck) begin
        if (tap_reset) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // rdata_reg is steady while the handshake is idle, so capture reads it directly
    always_comb begin
        shift_next = shift_reg;
        hold_next = hold_reg;
        req_tgl_next = req_tgl_reg;
        if (scan_capture) begin
            shift_next = {hold_reg[SCAN_W-1:DATA_W], rdata_reg};
        end else if (scan_shift) begin
            shift_next = {tdi, shift_reg[SCAN_W-1:1]};
        end else if (scan_update && (req_tgl_reg == ack_s2_reg)) begin
            hold_next = shift_reg;
            req_tgl_next = ~req_tgl_reg;
        end
        tdo_next = shift_next[0];
    end

    always_ff @(posedge tck) begin
        if (tap_reset) begin
            shift_reg <= '0;
            hold_reg <= '0;
            req_tgl_reg <= 1'b0;
            tdo_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            hold_reg <= hold_next;
            req_tgl_reg <= req_tgl_next;
            tdo_reg <= tdo_next;
        end
    end
    assign tdo = tdo_reg;

    // clk domain: synchronisers
    logic req_s1_reg, req_s2_reg, req_s3_reg;
    logic idle_s1_reg, idle_s2_reg, hreq_s1_reg, hreq_s2_reg;
    logic [EXT_W-1:0] ext_s1_reg, ext_s2_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
            idle_s1_reg <= 1'b0;
            idle_s2_reg <= 1'b0;
            hreq_s1_reg <= 1'b0;
            hreq_s2_reg <= 1'b0;
            ext_s1_reg <= '0;
            ext_s2_reg <= '0;
        end else begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            idle_s1_reg <= tap_idle;
            idle_s2_reg <= idle_s1_reg;
            hreq_s1_reg <= halt_request;
            hreq_s2_reg <= hreq_s1_reg;
            ext_s1_reg <= external_debug_input;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    logic req_evt, hold_rw;
    logic [ADDR_W-1:0] hold_addr;
    logic [DATA_W-1:0] hold_wdata;
    assign req_evt = req_s2_reg ^ req_s3_reg;
    assign hold_rw = hold_reg[SCAN_RW_BIT];
    assign hold_addr = hold_reg[SCAN_RW_BIT-1:SCAN_ADDR_LSB];
    assign hold_wdata = hold_reg[DATA_W-1:0];

    // clk domain: comparators
    logic [DATA_W-1:0] av_reg [NUM_UNITS], am_reg [NUM_UNITS], dv_reg [NUM_UNITS], dm_reg [NUM_UNITS];
    logic [DATA_W-1:0] av_next [NUM_UNITS], am_next [NUM_UNITS], dv_next [NUM_UNITS], dm_next [NUM_UNITS];
    logic [CV_W-1:0] cv_reg [NUM_UNITS], cv_next [NUM_UNITS];
    logic [CM_W-1:0] cm_reg [NUM_UNITS], cm_next [NUM_UNITS];
    logic [NUM_UNITS-1:0] addr_m, data_m, unit_m, chain_in, range_in;
    logic [CBUS_W-1:0] cbus [NUM_UNITS];
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic chain_reg, chain_next, range_reg, range_next, ack_out_reg, ack_out_next;

    assign chain_in = {1'b0, chain_reg};
    assign range_in = {1'b0, addr_m[1] & data_m[1]};

    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            assign cbus[u] = {ack_out_reg, access_valid, chain_in[u], range_in[u], ext_s2_reg[u],
                              core_ctrl};
            watch_comparator comparator_i (
                .addr_value(av_reg[u]),
                .addr_mask(am_reg[u]),
                .data_value(dv_reg[u]),
                .data_mask(dm_reg[u]),
                .ctrl_value(cv_reg[u]),
                .ctrl_mask(cm_reg[u]),
                .bus_addr(bus_addr),
                .bus_data(bus_data),
                .ctrl_bus(cbus[u]),
                .addr_match(addr_m[u]),
                .data_match(data_m[u]),
                .unit_match(unit_m[u])
            );
        end
    endgenerate

    // clk domain: registers and control
    logic stat_entry_reg, stat_entry_next, req_latch_reg, req_latch_next;
    logic req_out_reg, req_out_next, irq_en_reg, irq_en_next;
    logic bp_halt_reg, bp_halt_next, bp_abort_reg, bp_abort_next;
    logic abort_flag_reg, abort_flag_next, core_ack_prev_reg;
    logic hit, halt_evt, abort_evt, entry_evt;
    logic [STAT_W-1:0] stat_vec;
    logic [ADDR_W-1:0] unit_base;

    always_comb begin
        stat_vec = '0;
        stat_vec[STAT_REQ_ENTRY_BIT] = stat_entry_reg;
        stat_vec[STAT_COMPRESSED_BIT] = compressed_state_flag;
        stat_vec[STAT_HTRANS_BIT] = htrans1;
        stat_vec[STAT_IRQ_EN_BIT] = irq_en_reg;
        stat_vec[STAT_REQ_BIT] = req_latch_reg;
        stat_vec[STAT_ACK_BIT] = ack_out_reg;
    end

    assign hit = (|unit_m) & ~ctrl_reg[CTRL_DISABLE_BIT];
    assign halt_evt = hit & ~ctrl_reg[CTRL_MONITOR_BIT];
    assign abort_evt = hit & ctrl_reg[CTRL_MONITOR_BIT];
    assign entry_evt = core_internal_halt_ack & ~core_ack_prev_reg & req_out_reg;
    assign unit_base = hold_addr & ADDR_UNIT_MASK;

    always_comb begin
        ctrl_next = ctrl_reg;
        stat_entry_next = stat_entry_reg;
        av_next = av_reg;
        am_next = am_reg;
        dv_next = dv_reg;
        dm_next = dm_reg;
        cv_next = cv_reg;
        cm_next = cm_reg;
        rdata_next = rdata_reg;
        ack_tgl_next = ack_tgl_reg;
        if (req_evt) begin
            ack_tgl_next = ~ack_tgl_reg;
            if (hold_rw) begin
                if (hold_addr == ADDR_CTRL) begin
                    ctrl_next = hold_wdata[CTRL_W-1:0] & CTRL_WR_MASK;
                end
                if (hold_addr == ADDR_STAT) begin
                    stat_entry_next = hold_wdata[STAT_REQ_ENTRY_BIT];
                end
            end else begin
                rdata_next = '0;
                if (hold_addr == ADDR_CTRL) begin
                    rdata_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
                end
                if (hold_addr == ADDR_STAT) begin
                    rdata_next = {{(DATA_W-STAT_W){1'b0}}, stat_vec};
                end
            end
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (unit_base == (i == 0 ? ADDR_UNIT0 : ADDR_UNIT1)) begin
                    case (hold_addr[2:0])
                        WP_AV: begin
                            if (hold_rw) av_next[i] = hold_wdata;
                            else rdata_next = av_reg[i];
                        end
                        WP_AM: begin
                            if (hold_rw) am_next[i] = hold_wdata;
                            else rdata_next = am_reg[i];
                        end
                        WP_DV: begin
                            if (hold_rw) dv_next[i] = hold_wdata;
                            else rdata_next = dv_reg[i];
                        end
                        WP_DM: begin
                            if (hold_rw) dm_next[i] = hold_wdata;
                            else rdata_next = dm_reg[i];
                        end
                        WP_CV: begin
                            if (hold_rw) cv_next[i] = hold_wdata[CV_W-1:0];
                            else rdata_next = {{(DATA_W-CV_W){1'b0}}, cv_reg[i]};
                        end
                        WP_CM: begin
                            if (hold_rw) cm_next[i] = hold_wdata[CM_W-1:0];
                            else rdata_next = {{(DATA_W-CM_W){1'b0}}, cm_reg[i]};
                        end
                        default: begin
                            rdata_next = rdata_next;
                        end
                    endcase
                end
            end
        end
        // hardware set wins over a status write in the same cycle
        if (entry_evt) begin
            stat_entry_next = 1'b1;
        end
    end

    always_comb begin
        req_latch_next = idle_s2_reg ? ctrl_reg[CTRL_FORCE_REQ_BIT] : req_latch_reg;
        req_out_next = req_latch_reg | hreq_s2_reg;
        ack_out_next = core_internal_halt_ack | ctrl_reg[CTRL_FORCE_ACK_BIT];
        irq_en_next = ~(ack_out_next | ctrl_reg[CTRL_INHIBIT_BIT]);
        bp_halt_next = halt_evt;
        bp_abort_next = abort_evt;
        chain_next = addr_m[1] ? data_m[1] : chain_reg;
        range_next = addr_m[1] & data_m[1];
        abort_flag_next = abort_flag_reg;
        if (abort_evt && !external_abort) begin
            abort_flag_next = 1'b1;
        end else if (debug_abort_clear) begin
            abort_flag_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RESET;
            stat_entry_reg <= STAT_ENTRY_RESET;
            av_reg <= '{default: WP_RESET};
            am_reg <= '{default: WP_RESET};
            dv_reg <= '{default: WP_RESET};
            dm_reg <= '{default: WP_RESET};
            cv_reg <= '{default: '0};
            cm_reg <= '{default: '0};
            rdata_reg <= '0;
            ack_tgl_reg <= 1'b0;
            req_latch_reg <= 1'b0;
            req_out_reg <= 1'b0;
            ack_out_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            bp_halt_reg <= 1'b0;
            bp_abort_reg <= 1'b0;
            chain_reg <= 1'b0;
            range_reg <= 1'b0;
            abort_flag_reg <= 1'b0;
            core_ack_prev_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_entry_reg <= stat_entry_next;
            av_reg <= av_next;
            am_reg <= am_next;
            dv_reg <= dv_next;
            dm_reg <= dm_next;
            cv_reg <= cv_next;
            cm_reg <= cm_next;
            rdata_reg <= rdata_next;
            ack_tgl_reg <= ack_tgl_next;
            req_latch_reg <= req_latch_next;
            req_out_reg <= req_out_next;
            ack_out_reg <= ack_out_next;
            irq_en_reg <= irq_en_next;
            bp_halt_reg <= bp_halt_next;
            bp_abort_reg <= bp_abort_next;
            chain_reg <= chain_next;
            range_reg <= range_next;
            abort_flag_reg <= abort_flag_next;
            core_ack_prev_reg <= core_internal_halt_ack;
        end
    end

    assign combined_halt_request_out = req_out_reg;
    assign halt_acknowledge = ack_out_reg;
    assign core_interrupt_enable = irq_en_reg;
    assign breakpoint_halt = bp_halt_reg;
    assign breakpoint_abort = bp_abort_reg;
    assign debug_abort_flag = abort_flag_reg;
    assign chain_latch_output = chain_reg;
    assign range_match_output = range_reg;

    // checks
    default clocking main_cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence ctrl_write_s;
        req_evt && hold_rw && (hold_addr == ADDR_CTRL);
    endsequence
    sequence idle_closed_s;
        !idle_s2_reg [*2];
    endsequence

    ctrl_write_a: assert property (ctrl_write_s |=>
        ctrl_reg == ($past(hold_wdata[CTRL_W-1:0]) & CTRL_WR_MASK))
        else $error("control register did not take the scan write");
    sbz_zero_a: assert property (ctrl_reg[CTRL_SBZ_BIT] == 1'b0)
        else $error("reserved control bit is set");
    disable_gate_a: assert property (ctrl_reg[CTRL_DISABLE_BIT] |=> !bp_halt_reg && !bp_abort_reg)
        else $error("comparator output passed while disabled");
    mode_select_a: assert property ((|unit_m) && !ctrl_reg[CTRL_DISABLE_BIT] |=>
        (bp_halt_reg == !$past(ctrl_reg[CTRL_MONITOR_BIT])) && (bp_abort_reg == $past(ctrl_reg[CTRL_MONITOR_BIT])))
        else $error("match routed to wrong action");
    // skip the edge right after reset release, where the registers still hold reset values
    irq_gate_a: assert property (!$past(srst) |->
        irq_en_reg == !(ack_out_reg || $past(ctrl_reg[CTRL_INHIBIT_BIT])))
        else $error("interrupt enable wrong");
    req_hold_a: assert property (idle_closed_s |-> $stable(req_latch_reg))
        else $error("request latch moved outside run-test-idle");
    req_out_a: assert property (idle_s2_reg ##1 1'b1 |=>
        req_out_reg == ($past(ctrl_reg[CTRL_FORCE_REQ_BIT], 2) || $past(hreq_s2_reg)))
        else $error("combined request wrong");
    ack_out_a: assert property (!$past(srst) |->
        ack_out_reg == ($past(core_internal_halt_ack) || $past(ctrl_reg[CTRL_FORCE_ACK_BIT])))
        else $error("acknowledge output wrong");
    chain_latch_a: assert property (addr_m[1] |=> chain_reg == $past(data_m[1]))
        else $error("chain latch did not load");
    abort_prio_a: assert property (abort_evt && external_abort && !abort_flag_reg |=> !abort_flag_reg)
        else $error("debug abort flag set under external abort");
    entry_flag_a: assert property (entry_evt |=> stat_entry_reg)
        else $error("request entry flag not set");
endmodule : debug_control_status
`default_nettype wire

// File: verification/debugger_model.sv
`timescale 1ns/1ps
`default_nettype none
module debugger_model import debug_ctl_pkg::*; (
    output logic tck,
    output logic tap_reset,
    output logic tdi,
    output logic scan_capture,
    output logic scan_shift,
    output logic scan_update,
    output logic tap_idle,
    input wire logic tdo
);
    logic [CTRL_W-1:0] ctl_shadow = '0;
    task automatic tick(input int n);
        repeat (n) begin
            #24 tck = 1'b1;
            #24 tck = 1'b0;
        end
    endtask : tick
    task automatic scan(input logic [SCAN_W-1:0] w, output logic [DATA_W-1:0] rd);
        scan_capture = 1'b1;
        tick(1);
        scan_capture = 1'b0;
        scan_shift = 1'b1;
        for (int i = 0; i < SCAN_W; i++) begin
            tdi = w[i];
            if (i < DATA_W) rd[i] = tdo;
            tick(1);
        end
        scan_shift = 1'b0;
        tdi = ~tdi;
        scan_update = 1'b1;
        tick(1);
        scan_update = 1'b0;
        tick(20); // room for the clk-side handshake to return
    endtask : scan
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] unused;
        if (a == ADDR_CTRL) begin
            d[CTRL_SBZ_BIT] = 1'b0;
            ctl_shadow = d[CTRL_W-1:0];
        end
        scan({1'b1, a, d}, unused);
    endtask : write_reg
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] rd);
        scan({1'b0, a, 32'h0}, rd);
        scan({1'b0, a, 32'h0}, rd);
    endtask : read_reg
    task automatic write_ctrl(input logic [CTRL_W-1:0] v);
        write_reg(ADDR_CTRL, 32'(ctl_shadow | 6'h20));
        write_reg(ADDR_CTRL, 32'(v | 6'h20));
        write_reg(ADDR_CTRL, 32'(v));
    endtask : write_ctrl
    task automatic run_idle(input int n);
        tap_idle = 1'b1;
        tick(n);
        tap_idle = 1'b0;
    endtask : run_idle
    initial begin
        {tck, tdi, scan_capture, scan_shift, scan_update, tap_idle} = '0;
        tap_reset = 1'b1;
        tick(2);
        tap_reset = 1'b0;
    end
endmodule : debugger_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import debug_ctl_pkg::*; ;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic tck, tap_reset, tdi, scan_capture, scan_shift, scan_update, tap_idle, tdo;
    logic halt_request = 1'b0, core_internal_halt_ack = 1'b0, compressed_state_flag = 1'b0, htrans1 = 1'b0;
    logic access_valid = 1'b0, external_abort = 1'b0, debug_abort_clear = 1'b0;
    logic [EXT_W-1:0] external_debug_input = '0;
    logic [CORE_CTRL_W-1:0] core_ctrl = '0;
    logic [DATA_W-1:0] bus_addr = '0, bus_data = '0, rd;
    logic combined_halt_request_out, halt_acknowledge, core_interrupt_enable, breakpoint_halt;
    logic breakpoint_abort, debug_abort_flag, chain_latch_output, range_match_output;
    logic [DATA_W-1:0] unit1_tbl [6] = '{32'h4000, 32'h0, 32'h0, 32'hffff_ffff, 32'h0, 32'hff};
    logic [DATA_W-1:0] unit0_tbl [6] = '{32'h8000, 32'h0, 32'h0, 32'hffff_ffff, 32'h180, 32'h7f};
    int err_count = 0, compares = 0, seed = 32'hd3a7, ctl, exp_stat;
    debug_control_status DUT (.clk, .srst, .tck, .tap_reset, .tdi, .scan_capture, .scan_shift, .scan_update,
        .tap_idle, .tdo, .halt_request, .external_debug_input, .core_internal_halt_ack, .compressed_state_flag,
        .htrans1, .core_ctrl, .access_valid, .bus_addr, .bus_data, .external_abort, .debug_abort_clear,
        .combined_halt_request_out, .halt_acknowledge, .core_interrupt_enable, .breakpoint_halt,
        .breakpoint_abort, .debug_abort_flag, .chain_latch_output, .range_match_output);
    debugger_model dbg (.tck, .tap_reset, .tdi, .scan_capture, .scan_shift, .scan_update, .tap_idle, .tdo);
    always #50 clk = ~clk;
    always @(posedge clk) begin
        core_ctrl <= CORE_CTRL_W'($random(seed));
        bus_data <= $random(seed);
        external_debug_input <= EXT_W'($random(seed));
    end
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask : check
    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic hit(input logic [DATA_W-1:0] a);
        @(posedge clk);
        bus_addr <= a;
        access_valid <= 1'b1;
        @(posedge clk);
        bus_addr <= ~a;
        // the address no longer matches either unit, so valid may take any value
        access_valid <= 1'($random(seed));
        @(negedge clk);
    endtask : hit
    initial begin
        #2000000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(negedge clk);
        check(core_interrupt_enable, 1);
        check({combined_halt_request_out, halt_acknowledge, debug_abort_flag}, 0);
        dbg.read_reg(ADDR_CTRL, rd);
        check(rd, 0);
        repeat (6) begin
            ctl = $random(seed) & 32'h37;
            @(posedge clk) begin
                core_internal_halt_ack <= 1'($random(seed));
                halt_request <= 1'($random(seed));
            end
            dbg.write_ctrl(6'(ctl));
            dbg.read_reg(ADDR_CTRL, rd);
            check(rd, ctl);
            check(halt_acknowledge, core_internal_halt_ack | ctl[0]);
            check(core_interrupt_enable, !(core_internal_halt_ack | ctl[0] | ctl[2]));
        end
        @(posedge clk) begin
            core_internal_halt_ack <= 1'b0;
            halt_request <= 1'b0;
        end
        dbg.write_ctrl(6'h02);
        check(combined_halt_request_out, 0);
        dbg.run_idle(20);
        check(combined_halt_request_out, 1);
        @(posedge clk) begin
            core_internal_halt_ack <= 1'b1;
            compressed_state_flag <= 1'($random(seed));
            htrans1 <= 1'($random(seed));
        end
        repeat (3) @(negedge clk);
        exp_stat = {compressed_state_flag, htrans1, 3'h3};
        dbg.read_reg(ADDR_STAT, rd);
        check(rd, exp_stat | 32'h1000);
        dbg.write_reg(ADDR_STAT, 32'h0);
        dbg.read_reg(ADDR_STAT, rd);
        check(rd, exp_stat);
        dbg.write_ctrl(6'h00);
        dbg.run_idle(20);
        @(posedge clk) begin
            core_internal_halt_ack <= 1'b0;
            halt_request <= 1'b1;
        end
        for (int i = 0; i < 10 && combined_halt_request_out !== 1'b1; i++) @(negedge clk);
        check(combined_halt_request_out, 1);
        @(posedge clk) halt_request <= 1'b0;
        repeat (6) @(negedge clk);
        check(combined_halt_request_out, 0);
        dbg.write_ctrl(6'h20);
        for (int i = 0; i < 6; i++) begin
            dbg.write_reg(ADDR_UNIT1 + 5'(i), unit1_tbl[i]);
            dbg.write_reg(ADDR_UNIT0 + 5'(i), unit0_tbl[i]);
        end
        dbg.read_reg(ADDR_UNIT0 + 5'h4, rd);
        check(rd, unit0_tbl[4]);
        dbg.write_ctrl(6'h00);
        hit(32'h8000);
        check(breakpoint_halt, 0);
        hit(32'h4000);
        check({range_match_output, chain_latch_output, breakpoint_halt}, 3'h6);
        hit(32'h8000);
        check({breakpoint_halt, breakpoint_abort}, 2'h2);
        @(negedge clk);
        check(breakpoint_halt, 0);
        dbg.write_ctrl(6'h10);
        // a clear in the same cycle as the abort hit must lose to the set
        @(posedge clk) debug_abort_clear <= 1'($random(seed));
        hit(32'h8000);
        check({breakpoint_halt, breakpoint_abort}, 2'h1);
        check(debug_abort_flag, 1);
        @(posedge clk) debug_abort_clear <= 1'b1;
        @(posedge clk) begin
            debug_abort_clear <= 1'b0;
            external_abort <= 1'b1;
        end
        hit(32'h8000);
        repeat (2) @(negedge clk);
        check(debug_abort_flag, 0);
        @(posedge clk) external_abort <= 1'b0;
        dbg.write_ctrl(6'h30);
        hit(32'h8000);
        check({breakpoint_halt, breakpoint_abort}, 2'h0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
